// ===== cecx_defs.svh
// Constants of the control bus transmitter: offsets, fields, resets, timing
// Assumes a 200 MHz core clock; included by the bit timer, bus-free detector and top files
// Operation
// - Buffer holds one data byte plus its end-of-message bit
// - Transmit enable stays set over a message, cleared by done, error, soft reset or a software write
// - Start bit goes out once line reads high for configured bit cycles
// - First data bit loads shifter, sets started flag and raises interrupt
// - Each byte sends eight data bits, end-of-message, acknowledge, then checks
// - Acknowledged byte with end-of-message ends message, sets done, clears enable
// - Broadcast: acknowledge zero is error; otherwise acknowledge one is error
// - Any error raises interrupt, stops line at once, clears enable
// - Line low after own low time ends means arbitration lost
// - Empty buffer when next byte must start flags underrun
// - Underrun interrupt comes before acknowledge error interrupt
// - Soft reset aborts transmission and line drive at once
// - Soft reset clears every register except unit enable
// - Bus-free wait programmable from one to sixteen bit cycles
// - Bus-free counting starts one bit cycle after last falling edge
// - Reception is inhibited while transmitting
`ifndef CECX_DEFS_SVH
`define CECX_DEFS_SVH

`define CECX_CLK_MHZ      200
`define CECX_CNT_W        20

// Register offsets
`define CECX_OFS_UNIT_EN  8'h00
`define CECX_OFS_SRST     8'h04
`define CECX_OFS_TXEN     8'h08
`define CECX_OFS_TXCR     8'h0C
`define CECX_OFS_TXBUF    8'h10
`define CECX_OFS_TXSTAT   8'h14

// Field positions
`define CECX_CR_BRD       4
`define CECX_BUF_EOM      8
`define CECX_ST_STARTED   0
`define CECX_ST_DONE      1
`define CECX_ST_ARB       2
`define CECX_ST_ACK       3
`define CECX_ST_UR        4

// Reset values
`define CECX_FREE_RST     4'h0
`define CECX_BUF_RST      8'h00
`define CECX_FLAGS_RST    5'h00

// Timing, microseconds and cycles
`define CECX_START_LOW_US 3700
`define CECX_START_PER_US 4500
`define CECX_ZERO_LOW_US  1500
`define CECX_ONE_LOW_US   600
`define CECX_BIT_PER_US   2400
`define CECX_SAMPLE_US    1050
`define CECX_ARB_DLY_CYC  2
`define CECX_EOM_IDX      4'h8
`define CECX_LAST_IDX     4'h9

`endif

// ===== cecx_pkg.sv
// Types of the control bus transmitter
// Assumes nothing beyond the tool's package support
package cecx_pkg;
  typedef enum logic [1:0] {KIND_START, KIND_ZERO, KIND_ONE, KIND_ACK} cecx_kind_e;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_IRQ2} cecx_state_e;
  typedef logic [4:0] cecx_flags_t;
endpackage

// ===== cecx_tmr_if.sv
// Link between the sequencer and the bit timer
// Assumes both ends share core_clk
`timescale 1ns/1ps
interface cecx_tmr_if;
  import cecx_pkg::*;
  logic       start;
  logic       abort;
  cecx_kind_e kind;
  logic       drive_low;
  logic       arb_chk;
  logic       ack_smp;
  logic       done;
  modport ctl (output start, output abort, output kind,
               input drive_low, input arb_chk, input ack_smp, input done);
  modport tmr (input start, input abort, input kind,
               output drive_low, output arb_chk, output ack_smp, output done);
endinterface

// ===== cecx_bit_tmr.sv
// Bit timer: low phase, arbitration check, acknowledge sample, bit end
// Assumes a one-cycle start pulse per bit from the sequencer
`timescale 1ns/1ps
`include "cecx_defs.svh"
module cecx_bit_tmr import cecx_pkg::*; #(
  parameter int START_LOW = 740000,
  parameter int START_PER = 900000,
  parameter int ZERO_LOW  = 300000,
  parameter int ONE_LOW   = 120000,
  parameter int BIT_PER   = 480000,
  parameter int SAMPLE    = 210000
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  cecx_tmr_if.tmr   tm
);
  logic [`CECX_CNT_W-1:0] cnt_reg;
  logic                   run_reg;
  cecx_kind_e             kind_reg;

  function automatic logic [`CECX_CNT_W-1:0] low_len(cecx_kind_e k);
    case (k)
      KIND_START: low_len = `CECX_CNT_W'(START_LOW);
      KIND_ZERO:  low_len = `CECX_CNT_W'(ZERO_LOW);
      default:    low_len = `CECX_CNT_W'(ONE_LOW);
    endcase
  endfunction

  function automatic logic [`CECX_CNT_W-1:0] last_cnt(cecx_kind_e k);
    if (k == KIND_START) begin
      last_cnt = `CECX_CNT_W'(START_PER - 1);
    end else begin
      last_cnt = `CECX_CNT_W'(BIT_PER - 1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!nrst || tm.abort) begin
      run_reg  <= 1'b0;
      cnt_reg  <= '0;
      kind_reg <= KIND_START;
    end else if (tm.start) begin
      run_reg  <= 1'b1;
      cnt_reg  <= '0;
      kind_reg <= tm.kind;
    end else if (run_reg) begin
      if (cnt_reg == last_cnt(kind_reg)) begin
        run_reg <= 1'b0;
      end
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign tm.drive_low = run_reg && (cnt_reg < low_len(kind_reg));
  assign tm.arb_chk   = run_reg && (kind_reg != KIND_ACK) &&
                        (cnt_reg == low_len(kind_reg) + `CECX_CNT_W'(`CECX_ARB_DLY_CYC));
  assign tm.ack_smp   = run_reg && (kind_reg == KIND_ACK) &&
                        (cnt_reg == `CECX_CNT_W'(SAMPLE));
  assign tm.done      = run_reg && (cnt_reg == last_cnt(kind_reg));
endmodule

// ===== cecx_free_wait.sv
// Bus-free detector: counts whole high bit cycles after the last bit
// Assumes cec_in is synchronous to core_clk
`timescale 1ns/1ps
`include "cecx_defs.svh"
module cecx_free_wait #(
  parameter int BIT_PER = 480000
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       cec_in,
  input  wire logic [4:0] need,
  output logic            bus_free
);
  logic [`CECX_CNT_W-1:0] cyc_reg;
  logic [4:0]             bits_reg;
  logic                   armed_reg;
  logic                   prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= cec_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (!nrst || (prev_reg && !cec_in)) begin
      cyc_reg   <= '0;
      bits_reg  <= 5'h00;
      armed_reg <= 1'b0;
    end else if (cyc_reg == `CECX_CNT_W'(BIT_PER - 1)) begin
      cyc_reg <= '0;
      if (!armed_reg) begin
        armed_reg <= 1'b1;
      end else if (!cec_in) begin
        bits_reg <= 5'h00;
      end else if (bits_reg != 5'h1F) begin
        bits_reg <= bits_reg + 5'h01;
      end
    end else begin
      cyc_reg <= cyc_reg + 1'b1;
    end
  end

  assign bus_free = armed_reg && cec_in && (bits_reg >= need);
endmodule

// ===== cecx_tx.sv
// Control bus transmitter top: register port, sequencer, line driver
// Assumes synchronous cec_in and an external pull-up on the line
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps
`include "cecx_defs.svh"
module cecx_tx import cecx_pkg::*; #(
  parameter int START_LOW_CYC = `CECX_START_LOW_US * `CECX_CLK_MHZ,
  parameter int START_PER_CYC = `CECX_START_PER_US * `CECX_CLK_MHZ,
  parameter int ZERO_LOW_CYC  = `CECX_ZERO_LOW_US * `CECX_CLK_MHZ,
  parameter int ONE_LOW_CYC   = `CECX_ONE_LOW_US * `CECX_CLK_MHZ,
  parameter int BIT_PER_CYC   = `CECX_BIT_PER_US * `CECX_CLK_MHZ,
  parameter int SAMPLE_CYC    = `CECX_SAMPLE_US * `CECX_CLK_MHZ
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        cec_in,
  output logic             cec_out,
  output logic             cec_oe,
  output logic             tx_irq,
  output logic             rx_inhibit
);
  cecx_tmr_if tm ();

  cecx_state_e state_reg;
  logic        unit_en_reg;
  logic        srst_reg;
  logic        txen_reg;
  logic [3:0]  free_reg;
  logic        brd_reg;
  logic [7:0]  buf_data_reg;
  logic        buf_eom_reg;
  logic        buf_full_reg;
  cecx_flags_t flags_reg;
  logic [7:0]  sh_reg;
  logic        eom_reg;
  logic [3:0]  idx_reg;
  logic        ack_resp_reg;
  logic        start_reg;
  cecx_kind_e  kind_reg;
  logic        abort_reg;
  logic        oe_reg;
  logic        out_reg;
  logic        irq_reg;
  logic        busy_reg;
  logic [31:0] rdata_reg;

  logic        rst_all;
  logic        sub_nrst;
  logic        bus_free;
  logic [4:0]  need;
  logic        wr_unit;
  logic        wr_srst;
  logic        wr_txen;
  logic        wr_txcr;
  logic        wr_buf;
  logic        wr_stat;
  logic        go;
  logic        byte_end;
  logic        ack_bad;
  logic        step;
  logic        ev_load;
  logic        ev_arb;
  logic        ev_ur;
  logic        ev_ack;
  logic        ev_end;
  logic        err;
  cecx_flags_t flag_set;

  function automatic logic hit(logic [7:0] a, logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic cecx_kind_e bit_kind(logic [3:0] n, logic [7:0] d, logic e);
    if (n == `CECX_LAST_IDX) begin
      bit_kind = KIND_ACK;
    end else if (n == `CECX_EOM_IDX) begin
      bit_kind = e ? KIND_ONE : KIND_ZERO;
    end else begin
      bit_kind = d[3'(4'h7 - n)] ? KIND_ONE : KIND_ZERO;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  assign rst_all  = !nrst || srst_reg;
  assign sub_nrst = nrst && !srst_reg;
  assign need     = {1'b0, free_reg} + 5'h01;

  cecx_bit_tmr #(
    .START_LOW (START_LOW_CYC),
    .START_PER (START_PER_CYC),
    .ZERO_LOW  (ZERO_LOW_CYC),
    .ONE_LOW   (ONE_LOW_CYC),
    .BIT_PER   (BIT_PER_CYC),
    .SAMPLE    (SAMPLE_CYC)
  ) u_tmr (
    .core_clk (core_clk),
    .nrst     (sub_nrst),
    .tm       (tm.tmr)
  );

  cecx_free_wait #(
    .BIT_PER (BIT_PER_CYC)
  ) u_free (
    .core_clk (core_clk),
    .nrst     (sub_nrst),
    .cec_in   (cec_in),
    .need     (need),
    .bus_free (bus_free)
  );

  assign tm.start = start_reg;
  assign tm.kind  = kind_reg;
  assign tm.abort = abort_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and events
  assign wr_unit = reg_wr && hit(reg_addr, `CECX_OFS_UNIT_EN);
  assign wr_srst = reg_wr && hit(reg_addr, `CECX_OFS_SRST);
  assign wr_txen = reg_wr && hit(reg_addr, `CECX_OFS_TXEN);
  assign wr_txcr = reg_wr && hit(reg_addr, `CECX_OFS_TXCR);
  assign wr_buf  = reg_wr && hit(reg_addr, `CECX_OFS_TXBUF);
  assign wr_stat = reg_wr && hit(reg_addr, `CECX_OFS_TXSTAT);

  assign go       = (state_reg == ST_IDLE) && unit_en_reg && txen_reg && bus_free;
  assign byte_end = (state_reg == ST_BITS) && tm.done && (idx_reg == `CECX_LAST_IDX);
  assign ack_bad  = brd_reg ? !ack_resp_reg : ack_resp_reg;
  assign step     = (state_reg == ST_BITS) && tm.done && (idx_reg != `CECX_LAST_IDX);

  always_comb begin
    ev_arb  = ((state_reg == ST_START) || (state_reg == ST_BITS)) &&
              tm.arb_chk && !cec_in;
    ev_ur   = byte_end && !eom_reg && !buf_full_reg;
    ev_ack  = byte_end && ack_bad && !ev_ur;
    ev_end  = byte_end && !ack_bad && eom_reg;
    ev_load = ((state_reg == ST_START) && tm.done) ||
              (byte_end && !ack_bad && !eom_reg && buf_full_reg);
    err     = ev_arb || ev_ur || ev_ack;
    flag_set = `CECX_FLAGS_RST;
    flag_set[`CECX_ST_STARTED] = ev_load;
    flag_set[`CECX_ST_DONE]    = ev_end;
    flag_set[`CECX_ST_ARB]     = ev_arb;
    flag_set[`CECX_ST_ACK]     = ev_ack || (state_reg == ST_IRQ2);
    flag_set[`CECX_ST_UR]      = ev_ur;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      unit_en_reg <= 1'b0;
    end else if (wr_unit) begin
      unit_en_reg <= reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= wr_srst && reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      txen_reg <= 1'b0;
    end else if (ev_end || err) begin
      txen_reg <= 1'b0;
    end else if (wr_txen) begin
      txen_reg <= reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      free_reg <= `CECX_FREE_RST;
      brd_reg  <= 1'b0;
    end else if (wr_txcr) begin
      free_reg <= reg_wdata[3:0];
      brd_reg  <= reg_wdata[`CECX_CR_BRD];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      buf_data_reg <= `CECX_BUF_RST;
      buf_eom_reg  <= 1'b0;
      buf_full_reg <= 1'b0;
    end else begin
      if (wr_buf) begin
        buf_data_reg <= reg_wdata[7:0];
        buf_eom_reg  <= reg_wdata[`CECX_BUF_EOM];
      end
      buf_full_reg <= wr_buf || (buf_full_reg && !ev_load);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      flags_reg <= `CECX_FLAGS_RST;
    end else if (wr_stat) begin
      flags_reg <= (flags_reg & ~reg_wdata[4:0]) | flag_set;
    end else begin
      flags_reg <= flags_reg | flag_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (err) begin
            state_reg <= ST_IDLE;
          end else if (ev_load) begin
            state_reg <= ST_BITS;
          end
        end
        ST_BITS: begin
          if (ev_ur && ack_bad) begin
            state_reg <= ST_IRQ2;
          end else if (err || ev_end) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      sh_reg       <= 8'h00;
      eom_reg      <= 1'b0;
      idx_reg      <= 4'h0;
      ack_resp_reg <= 1'b0;
    end else begin
      if (ev_load) begin
        sh_reg  <= buf_data_reg;
        eom_reg <= buf_eom_reg;
        idx_reg <= 4'h0;
      end else if (step) begin
        idx_reg <= idx_reg + 4'h1;
      end
      if (tm.ack_smp) begin
        ack_resp_reg <= cec_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      start_reg <= 1'b0;
      kind_reg  <= KIND_START;
      abort_reg <= 1'b0;
    end else begin
      start_reg <= go || ev_load || (step && !err);
      abort_reg <= err;
      if (go) begin
        kind_reg <= KIND_START;
      end else if (ev_load) begin
        kind_reg <= bit_kind(4'h0, buf_data_reg, buf_eom_reg);
      end else if (step) begin
        kind_reg <= bit_kind(idx_reg + 4'h1, sh_reg, eom_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line, interrupt and busy outputs
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      oe_reg  <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      oe_reg  <= tm.drive_low && !err && !abort_reg;
      out_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      irq_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      irq_reg  <= |flag_set;
      busy_reg <= go || (state_reg != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge core_clk) begin
    if (rst_all || !reg_rd) begin
      rdata_reg <= 32'h0000_0000;
    end else if (hit(reg_addr, `CECX_OFS_UNIT_EN)) begin
      rdata_reg <= {31'h0000_0000, unit_en_reg};
    end else if (hit(reg_addr, `CECX_OFS_TXEN)) begin
      rdata_reg <= {31'h0000_0000, txen_reg};
    end else if (hit(reg_addr, `CECX_OFS_TXCR)) begin
      rdata_reg <= {27'h000_0000, brd_reg, free_reg};
    end else if (hit(reg_addr, `CECX_OFS_TXBUF)) begin
      rdata_reg <= {23'h00_0000, buf_eom_reg, buf_data_reg};
    end else if (hit(reg_addr, `CECX_OFS_TXSTAT)) begin
      rdata_reg <= {26'h000_0000, busy_reg, flags_reg};
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign cec_out    = out_reg;
  assign cec_oe     = oe_reg;
  assign tx_irq     = irq_reg;
  assign rx_inhibit = busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst_all);

  sequence s_released;
    !cec_oe [*3];
  endsequence

  sequence s_two_irqs;
    tx_irq ##1 (tx_irq && flags_reg[`CECX_ST_ACK] && flags_reg[`CECX_ST_UR]);
  endsequence

  chk_txen_hold: assert property (
    (state_reg != ST_IDLE) && txen_reg && !err && !ev_end && !wr_txen |=> txen_reg)
    else $error("transmit enable dropped mid message");

  chk_start_free: assert property (
    $rose(rx_inhibit) |-> $past(bus_free) && $past(txen_reg))
    else $error("start bit without free bus");

  chk_load_flag: assert property (
    ev_load |=> tx_irq && flags_reg[`CECX_ST_STARTED] && (idx_reg == 4'h0))
    else $error("load did not flag start");

  chk_ack_bit: assert property (
    byte_end |-> (kind_reg == KIND_ACK))
    else $error("byte ended before acknowledge bit");

  chk_end_flag: assert property (
    ev_end |=> !txen_reg && flags_reg[`CECX_ST_DONE] && (state_reg == ST_IDLE))
    else $error("message end not completed");

  chk_ack_rule: assert property (
    byte_end && (brd_reg ? !ack_resp_reg : ack_resp_reg) && buf_full_reg
    |=> flags_reg[`CECX_ST_ACK] && !txen_reg)
    else $error("acknowledge error missed");

  chk_err_stop: assert property (
    err |=> s_released)
    else $error("line still driven after error");

  chk_arb_flag: assert property (
    ev_arb |=> flags_reg[`CECX_ST_ARB] && (state_reg == ST_IDLE))
    else $error("arbitration loss not flagged");

  chk_underrun: assert property (
    byte_end && !eom_reg && !buf_full_reg |=> flags_reg[`CECX_ST_UR])
    else $error("underrun not flagged");

  chk_irq_order: assert property (
    ev_ur && ack_bad |=> s_two_irqs)
    else $error("underrun and acknowledge order wrong");

  chk_soft_reset: assert property (disable iff (!nrst)
    srst_reg |=> (state_reg == ST_IDLE) && !cec_oe && (flags_reg == 5'h00) && !txen_reg)
    else $error("soft reset left state behind");

  chk_flag_sticky: assert property (
    flags_reg[`CECX_ST_DONE] && !wr_stat |=> flags_reg[`CECX_ST_DONE])
    else $error("flag cleared without software");
endmodule

// ===== cecx_node_model.sv
// Other node on the control line: acknowledges and can collide
// Assumes a pulled-up line sampled on core_clk; pull high = line low
`timescale 1ns/1ps
module cecx_node_model #(
  parameter int BIT_PER   = 30,
  parameter int ACK_LOW   = 20,
  parameter int CLASH_LOW = 25
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic cec_line,
  input  wire logic ack_low,
  input  wire logic clash,
  output logic      pull
);
  logic prev;
  int   idx;
  int   hi_cnt;
  int   nidx;
  int   pull_cnt;
  assign pull = (pull_cnt != 0);
  assign nidx = (hi_cnt > BIT_PER) ? 0 : idx + 1;
  always_ff @(posedge core_clk) begin
    prev   <= cec_line;
    hi_cnt <= cec_line ? hi_cnt + 1 : 0;
    if (!nrst) begin
      idx      <= 0;
      pull_cnt <= 0;
    end else if (prev && !cec_line) begin
      idx <= nidx;
      if (nidx % 10 == 0 && nidx != 0 && ack_low) begin
        pull_cnt <= ACK_LOW;
      end else if (nidx == 1 && clash) begin
        pull_cnt <= CLASH_LOW;
      end
    end else if (pull_cnt != 0) begin
      pull_cnt <= pull_cnt - 1;
    end
  end
endmodule

// ===== tb_cecx.sv
// Self-checking bench of the control bus transmitter
// Assumes design files and node model compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic        core_clk  = 0;
  logic        nrst      = 0;
  logic        reg_wr    = 0;
  logic        reg_rd    = 0;
  logic        ack_low   = 0;
  logic        clash     = 0;
  logic        prev_ln   = 1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  d0;
  logic [7:0]  d1;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] rdata;
  logic [19:0] sh        = 20'h0;
  logic [7:0]  regs [5]  = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14};
  wire  [31:0] reg_rdata;
  wire         cec_out, cec_oe, tx_irq, rx_inhibit, pull, cec_in;
  int          failures  = 0;
  int          n_checks  = 0;
  int          seed      = 32'hB1AA;
  int          cyc = 0, lo = 0, f_prev = 0, f_last = 0, cur_free = 0;
  int          n_irq = 0, irq_base = 0;
  localparam int T_SLOW = 40, T_SPER = 50, T_ZERO = 20, T_ONE = 8, T_BIT = 30, T_SMP = 12;
  assign cec_in = !(cec_oe && !cec_out) && !pull;
  cecx_tx #(.START_LOW_CYC(T_SLOW), .START_PER_CYC(T_SPER), .ZERO_LOW_CYC(T_ZERO),
    .ONE_LOW_CYC(T_ONE), .BIT_PER_CYC(T_BIT), .SAMPLE_CYC(T_SMP)) i_dut (.core_clk(core_clk),
    .nrst(nrst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cec_in(cec_in), .cec_out(cec_out), .cec_oe(cec_oe),
    .tx_irq(tx_irq), .rx_inhibit(rx_inhibit));
  cecx_node_model i_node (.core_clk(core_clk), .nrst(nrst),
    .cec_line(cec_in), .ack_low(ack_low), .clash(clash), .pull(pull));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Line decoder: low length gives start, zero or one
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (tx_irq === 1'h1) n_irq <= n_irq + 1;
    prev_ln <= cec_in;
    if (cec_oe) `CHK(rx_inhibit, 1'h1)
    if (!cec_in) lo <= lo + 1;
    if (prev_ln && !cec_in) begin
      f_prev <= f_last;
      f_last <= cyc;
    end
    if (!prev_ln && cec_in) begin
      lo <= 0;
      if (lo >= 30) begin
        sh <= 20'h0;
        if (f_prev != 0) `CHK(f_last - f_prev >= (cur_free + 2) * 30, 1'h1)
      end else sh <= {sh[18:0], lo < 14};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1 rdata = reg_rdata;
  endtask
  task automatic wait_st(input logic [5:0] m);
    int i;
    for (i = 0; i < 4000; i++) begin
      rd(8'h14);
      if ((rdata[4:0] & m[4:0]) != 5'h00 && rdata[5] == m[5]) break;
    end
    if (i == 4000) begin
      failures++;
      results();
    end
  endtask
  task automatic chk_regs(input logic ue);
    foreach (regs[i]) begin
      rd(regs[i]);
      `CHK(rdata, {31'h0, ue && i == 0})
    end
    rd(8'h3C);
    `CHK(rdata, 32'h0)
  endtask
  task automatic launch(input logic [7:0] d, input logic eom, input logic brd);
    irq_base = n_irq;
    cur_free = $random(seed) & 15;
    wr(8'h0C, {27'h0, brd, cur_free[3:0]});
    wr(8'h10, {23'h0, eom, d});
    wr(8'h08, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'h1;
    chk_regs(1'h0);
    wr(8'h00, 32'h1);
    for (int k = 0; k < 4; k++) begin
      d0 = 8'($random(seed));
      ack_low <= !k[0];
      launch(d0, 1'h1, k[0]);
      wait_st(6'h1E);
      `CHK(rdata[5:0], 6'h03)
      `CHK(n_irq - irq_base, 2)
      `CHK(sh[9:0], {d0, 1'h1, k[0]})
      rd(8'h14);
      `CHK(rdata[5:0], 6'h03)
      rd(8'h08);
      `CHK(rdata, 32'h0)
      wr(8'h14, 32'h1F);
    end
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    ack_low <= 1'h1;
    launch(d0, 1'h0, 1'h0);
    wait_st(6'h21);
    wr(8'h10, {23'h1, d1});
    wait_st(6'h1E);
    `CHK(rdata[5:0], 6'h03)
    `CHK(n_irq - irq_base, 3)
    `CHK(sh, {d0, 2'h0, d1, 2'h2})
    wr(8'h14, 32'h1F);
    for (int k = 0; k < 4; k++) begin
      ack_low <= k[0];
      launch(8'($random(seed)), !k[1], k[0]);
      wait_st(6'h08);
      `CHK(rdata[4:0], {k[1], 4'h9})
      `CHK(n_irq - irq_base, 2 + k[1])
      `CHK(cec_oe, 1'h0)
      rd(8'h08);
      `CHK(rdata, 32'h0)
      wr(8'h14, 32'h1F);
    end
    ack_low <= 1'h1;
    clash <= 1'h1;
    launch(8'($random(seed)), 1'h1, 1'h0);
    wait_st(6'h04);
    `CHK(rdata[4:0], 5'h05)
    `CHK(n_irq - irq_base, 2)
    `CHK(cec_oe, 1'h0)
    clash <= 1'h0;
    wr(8'h14, 32'h1F);
    launch(8'($random(seed)), 1'h1, 1'h0);
    for (int i = 0; i < 3000 && cec_oe !== 1'h1; i++) @(posedge core_clk);
    `CHK(cec_oe, 1'h1)
    wr(8'h04, 32'h1);
    repeat (2) @(posedge core_clk);
    #1 `CHK(cec_oe, 1'h0)
    chk_regs(1'h1);
    results();
  end
endmodule
